// ### design/pmw_burst_write.sv
/*
  PCI master burst write path: local master request, bus arbitration,
  address phase, and data phases with both ready handshakes.
  Assumes one PCI clock, inputs synchronous, termination handled elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmw_params.svh"
module pmw_burst_write #(
  parameter int CNT_W = `PMW_CNT_W
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  // Local master side
  input  wire logic                   local_wide_request_n,
  input  wire logic [`PMW_DATA_W-1:0] l_ad_in,
  input  wire logic [`PMW_BE_W-1:0]   local_byte_enables_n,
  input  wire logic [CNT_W-1:0]       requested_burst_length,
  input  wire logic                   local_ready_n,
  output logic                        local_grant_n,
  output logic                        local_xfer_ack_n,
  output logic [3:0]                  master_phase_code,
  output logic [CNT_W-1:0]            remaining_dword_count,
  // PCI side
  input  wire logic                   gntn,
  input  wire logic                   trdyn,
  output logic                        reqn,
  output logic                        framen,
  output logic                        framen_oe,
  output logic                        irdyn,
  output logic                        irdyn_oe,
  output logic [`PMW_DATA_W-1:0]      ad_out,
  output logic                        ad_oe,
  output logic [`PMW_BE_W-1:0]        cben_out,
  output logic                        cben_oe
);
  // ****************************************
  // State
  // ****************************************
  pmw_pkg::pmw_state_e st_r, st_nxt;
  logic [3:0]             phase_r, phase_nxt;
  logic                   reqn_r, reqn_nxt, lgnt_r, lgnt_nxt;
  logic                   frame_r, frame_nxt, irdy_r, irdy_nxt;
  logic                   oe_r, oe_nxt;
  logic                   req_d_r, gnt_d_r, rdy_d_r;
  logic [`PMW_DATA_W-1:0] ad_r, ad_nxt, addr_r, addr_nxt;
  logic [`PMW_BE_W-1:0]   cbe_r, cbe_nxt, cmd_r, cmd_nxt;
  logic [CNT_W-1:0]       len_r, len_nxt;
  pmw_pkg::pmw_word_s     stage_r, stage_nxt;
  logic                   stage_v_r, stage_v_nxt;
  logic                   phase_done, cnt_load, local_take;

  initial begin
    if (CNT_W < 2) $error("burst length width too small");
  end

  assign phase_done = !irdy_r && !trdyn;
  assign cnt_load   = st_r == pmw_pkg::PMW_ADDR;
  // A word is taken in the cycle its acknowledge shows, so the local master
  // never sees one word taken twice; needs two ready cycles and room
  assign local_take = (st_r == pmw_pkg::PMW_DATA) && !rdy_d_r && !local_ready_n &&
                      (!stage_v_r || irdy_r || phase_done);

  pmw_dword_counter #(.CNT_W(CNT_W)) u_cnt (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .load     (cnt_load),
    .load_val (len_r),
    .step     (phase_done),
    .count    (remaining_dword_count),
    .last     ()
  );

  // ****************************************
  // Sequencer and bus drive
  // ****************************************
  // Next values; staging one word lets the bus keep order even when the
  // target stalls, at the cost of one register stage.
  always_comb begin
    st_nxt      = st_r;
    phase_nxt   = phase_r;
    reqn_nxt    = reqn_r;
    lgnt_nxt    = `PMW_NEGATED_N;
    frame_nxt   = frame_r;
    irdy_nxt    = irdy_r;
    oe_nxt      = oe_r;
    ad_nxt      = ad_r;
    cbe_nxt     = cbe_r;
    addr_nxt    = addr_r;
    cmd_nxt     = cmd_r;
    len_nxt     = len_r;
    stage_nxt   = stage_r;
    stage_v_nxt = stage_v_r;
    case (st_r)
      pmw_pkg::PMW_IDLE: begin
        phase_nxt = `PMW_PH_IDLE;
        if (!local_wide_request_n) begin
          reqn_nxt = `PMW_ASSERTED_N;
          addr_nxt = l_ad_in;
          cmd_nxt  = local_byte_enables_n;
          len_nxt  = requested_burst_length;
          st_nxt   = pmw_pkg::PMW_REQ;
        end
      end
      pmw_pkg::PMW_REQ: begin
        if (!gntn && frame_r) begin
          lgnt_nxt = `PMW_ASSERTED_N;
          st_nxt   = pmw_pkg::PMW_LOAD;
        end
      end
      pmw_pkg::PMW_LOAD: begin
        if (!req_d_r && !gnt_d_r) begin
          phase_nxt = `PMW_PH_ADDR_LOAD;
          st_nxt    = pmw_pkg::PMW_ADDR;
        end
      end
      pmw_pkg::PMW_ADDR: begin
        if (!gntn) begin
          frame_nxt = `PMW_ASSERTED_N;
          oe_nxt    = 1'b1;
          ad_nxt    = addr_r;
          cbe_nxt   = cmd_r;
          phase_nxt = `PMW_PH_BUS_XACT;
          st_nxt    = pmw_pkg::PMW_DATA;
        end
      end
      default: begin
        reqn_nxt  = `PMW_NEGATED_N;
        frame_nxt = `PMW_ASSERTED_N;
        // irdy only while ad holds a real word, so no junk phase completes
        if (irdy_r || phase_done) begin
          if (stage_v_r) begin
            ad_nxt      = stage_r.data;
            cbe_nxt     = stage_r.be_n;
            irdy_nxt    = `PMW_ASSERTED_N;
            stage_v_nxt = local_take;
          end else if (local_take) begin
            ad_nxt   = l_ad_in;
            cbe_nxt  = local_byte_enables_n;
            irdy_nxt = `PMW_ASSERTED_N;
          end else begin
            irdy_nxt = `PMW_NEGATED_N;
          end
        end else if (local_take) begin
          stage_v_nxt = 1'b1;
        end
        if (local_take) begin
          stage_nxt = '{data: l_ad_in, be_n: local_byte_enables_n};
        end
      end
    endcase
  end

  // Registers, strobes inactive at reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r      <= pmw_pkg::PMW_IDLE;
      phase_r   <= `PMW_PH_IDLE;
      reqn_r    <= `PMW_NEGATED_N;
      lgnt_r    <= `PMW_NEGATED_N;
      frame_r   <= `PMW_NEGATED_N;
      irdy_r    <= `PMW_NEGATED_N;
      oe_r      <= 1'b0;
      req_d_r   <= `PMW_NEGATED_N;
      gnt_d_r   <= `PMW_NEGATED_N;
      rdy_d_r   <= `PMW_NEGATED_N;
      ad_r      <= '0;
      cbe_r     <= '0;
      addr_r    <= '0;
      cmd_r     <= '0;
      len_r     <= '0;
      stage_r   <= '0;
      stage_v_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      phase_r   <= phase_nxt;
      reqn_r    <= reqn_nxt;
      lgnt_r    <= lgnt_nxt;
      frame_r   <= frame_nxt;
      irdy_r    <= irdy_nxt;
      oe_r      <= oe_nxt;
      req_d_r   <= local_wide_request_n;
      gnt_d_r   <= gntn;
      rdy_d_r   <= local_ready_n;
      ad_r      <= ad_nxt;
      cbe_r     <= cbe_nxt;
      addr_r    <= addr_nxt;
      cmd_r     <= cmd_nxt;
      len_r     <= len_nxt;
      stage_r   <= stage_nxt;
      stage_v_r <= stage_v_nxt;
    end
  end

  assign master_phase_code = phase_r;
  assign reqn              = reqn_r;
  assign local_grant_n     = lgnt_r;
  assign local_xfer_ack_n  = local_take ? `PMW_ASSERTED_N : `PMW_NEGATED_N;
  assign framen            = frame_r;
  assign framen_oe         = oe_r;
  assign irdyn             = irdy_r;
  assign irdyn_oe          = oe_r;
  assign ad_out            = ad_r;
  assign ad_oe             = oe_r;
  assign cben_out          = cbe_r;
  assign cben_oe           = oe_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_load_seen;
    st_r == pmw_pkg::PMW_ADDR && !gntn;
  endsequence

  AST_FRAME_START: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_load_seen |=> !framen && ad_out == $past(addr_r) && cben_out == $past(cmd_r))
    else $error("frame start wrong");
  AST_PHASE_XACT: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(framen) |-> master_phase_code == `PMW_PH_BUS_XACT)
    else $error("phase code not bus transaction");
  AST_LOAD_PHASE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_r == pmw_pkg::PMW_LOAD && !req_d_r && !gnt_d_r)
      |=> master_phase_code == `PMW_PH_ADDR_LOAD)
    else $error("address loading missed");
  AST_REQ: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_r == pmw_pkg::PMW_IDLE && !local_wide_request_n) |=> !reqn)
    else $error("bus request missing");
  AST_LGNT: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_r == pmw_pkg::PMW_REQ && !gntn && framen) |=> !local_grant_n)
    else $error("local grant missing");
  AST_CNT_LOAD: assert property (@(posedge clk_sys) disable iff (!resetn)
    cnt_load |=> remaining_dword_count == $past(len_r))
    else $error("counter not loaded");
  AST_REQ_DROP: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(framen) |=> reqn)
    else $error("bus request held");
  AST_IRDY: assert property (@(posedge clk_sys) disable iff (!resetn)
    !local_xfer_ack_n |=> !irdyn)
    else $error("irdy dropped");
  AST_ACK_ONLY_RDY: assert property (@(posedge clk_sys) disable iff (!resetn)
    !local_xfer_ack_n |-> !local_ready_n && !$past(local_ready_n))
    else $error("ack without ready");
  AST_FRAME_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_r == pmw_pkg::PMW_DATA) |=> !framen)
    else $error("frame released");
endmodule
`default_nettype wire

// ### design/pmw_dword_counter.sv
/*
  Remaining-dword counter: loads the burst length, steps down once per
  completed data phase. Assumes a single clock and async low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmw_params.svh"
module pmw_dword_counter #(
  parameter int CNT_W = `PMW_CNT_W
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  input  wire logic             step,
  // State
  output logic      [CNT_W-1:0] count,
  output logic                  last
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  initial begin
    if (CNT_W < 2) $error("counter too narrow");
  end

  // Load wins over step; never wraps below zero
  always_comb begin
    count_nxt = count_r;
    if (load) begin
      count_nxt = load_val;
    end else if (step && count_r != '0) begin
      count_nxt = count_r - CNT_W'(1);
    end
  end

  // Counter register, cleared on reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
  assign last  = (count_r == CNT_W'(1));

  AST_CNT_STEP: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!load && step && count_r != '0) |=> count_r == $past(count_r) - CNT_W'(1))
    else $error("counter did not step");
endmodule
`default_nettype wire

// ### design/pmw_params.svh
/*
  Constants for the PCI master burst write path: phase codes, widths and
  strobe levels. Assumes inclusion by bare name from design files.
*/
`ifndef PMW_PARAMS_SVH
`define PMW_PARAMS_SVH

// ****************************************
// Phase codes and levels
// ****************************************
`define PMW_PH_IDLE      4'h0
`define PMW_PH_ADDR_LOAD 4'h1
`define PMW_PH_BUS_XACT  4'h2
`define PMW_PH_BUS_TERM  4'h3
`define PMW_ASSERTED_N   1'b0
`define PMW_NEGATED_N    1'b1
`define PMW_DATA_W       32
`define PMW_BE_W         4
`define PMW_CNT_W        8
`define PMW_CMD_MEM_WR   4'h7

`endif

// ### design/pmw_pkg.sv
/*
  Types for the PCI master burst write path.
  Assumes pmw_params.svh is reachable on the include path.
*/
`include "pmw_params.svh"
package pmw_pkg;
  // One staged word with its byte enables
  typedef struct packed {
    logic [`PMW_DATA_W-1:0] data;
    logic [`PMW_BE_W-1:0]   be_n;
  } pmw_word_s;

  // One-hot states of the master sequencer
  typedef enum logic [4:0] {
    PMW_IDLE  = 5'h01,
    PMW_REQ   = 5'h02,
    PMW_LOAD  = 5'h04,
    PMW_ADDR  = 5'h08,
    PMW_DATA  = 5'h10
  } pmw_state_e;
endpackage

// ### tb/pmw_burst_write_tb.sv
/*
  Self-checking bench for the burst write path: bursts of random length
  and data with stalls on both sides, reset after each burst with the frame still held.
  Assumes the target model above and the design package.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmw_params.svh"
module pmw_burst_write_tb;
  logic        clk_sys, resetn, local_wide_request_n, local_ready_n, stall;
  logic [31:0] l_ad_in, ad_out, seed;
  logic [3:0]  local_byte_enables_n, master_phase_code, cben_out;
  logic [7:0]  requested_burst_length, remaining_dword_count, cnt_exp;
  logic        local_grant_n, local_xfer_ack_n, reqn, framen, framen_oe, irdyn;
  logic        irdyn_oe, ad_oe, cben_oe, gntn, trdyn, dec_pend;
  int          errors, num_checks, rx;
  pmw_pkg::pmw_word_s src_q[$], exp_q[$];

  pmw_burst_write i_dut (.clk_sys, .resetn, .local_wide_request_n, .l_ad_in,
    .local_byte_enables_n, .requested_burst_length, .local_ready_n, .local_grant_n,
    .local_xfer_ack_n, .master_phase_code, .remaining_dword_count, .gntn, .trdyn,
    .reqn, .framen, .framen_oe, .irdyn, .irdyn_oe, .ad_out, .ad_oe, .cben_out,
    .cben_oe);
  pmw_pci_target_model i_far (.clk_sys, .resetn, .reqn, .framen, .irdyn, .stall,
    .limit(requested_burst_length), .gntn, .trdyn);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Reset in whatever state the burst is in; strobes must go quiet
  task automatic do_reset(input int cycles);
    resetn = 1'b0;
    #1;
    src_q.delete();
    exp_q.delete();
    check("phase", master_phase_code, `PMW_PH_IDLE);
    check("count", remaining_dword_count, 8'h00);
    check("strobes", {reqn, framen, irdyn, local_grant_n, local_xfer_ack_n}, 5'h1F);
    check("enables", {framen_oe, irdyn_oe, ad_oe, cben_oe}, 4'h0);
    repeat (cycles) @(negedge clk_sys);
    resetn = 1'b1;
  endtask

  // One burst; cycle figures follow the fixed request walk
  task automatic run_xact(input logic [7:0] n);
    logic [31:0] addr;
    addr = rnd();
    local_wide_request_n = 1'b0;
    l_ad_in = addr;
    local_byte_enables_n = `PMW_CMD_MEM_WR;
    requested_burst_length = n;
    rx = 0;
    for (int i = 0; i < n; i++) src_q.push_back('{data: rnd(), be_n: 4'(rnd())});
    @(negedge clk_sys);
    check("reqn", reqn, 1'b0);
    repeat (2) @(negedge clk_sys);
    check("grant", local_grant_n, 1'b0);
    @(negedge clk_sys);
    check("phase load", master_phase_code, `PMW_PH_ADDR_LOAD);
    check("grant pulse", local_grant_n, 1'b1);
    local_wide_request_n = 1'b1;
    @(negedge clk_sys);
    check("frame", {framen, framen_oe, irdyn_oe, ad_oe, cben_oe, ad_out, cben_out},
          {5'b01111, addr, `PMW_CMD_MEM_WR});
    check("phase xact", master_phase_code, `PMW_PH_BUS_XACT);
    @(negedge clk_sys);
    check("count load", remaining_dword_count, n);
    for (int i = 0; i < 300 && rx < n; i++) @(negedge clk_sys);
    check("words moved", rx, n);
    check("count end", remaining_dword_count, 8'h00);
    check("reqn end", reqn, 1'b1);
    check("frame held", framen, 1'b0);
    do_reset(2);
  endtask

  // ****************************************
  // Local master and stall drivers
  // ****************************************
  // Ready only while a word is on hand, randomly held off
  always @(negedge clk_sys) begin
    stall <= rnd() > 32'hB0000000;
    if (src_q.size() != 0 && master_phase_code == `PMW_PH_BUS_XACT) begin
      {l_ad_in, local_byte_enables_n} <= src_q[0];
      local_ready_n <= rnd() > 32'hC0000000;
    end else begin
      local_ready_n <= 1'b1;
    end
  end

  // ****************************************
  // Monitors
  // ****************************************
  always @(posedge clk_sys) begin
    if (resetn) begin
      if (!local_xfer_ack_n) begin
        check("ready at take", local_ready_n, 1'b0);
        check("word on hand", src_q.size() != 0, 1'b1);
        if (src_q.size() != 0) exp_q.push_back(src_q.pop_front());
      end
      if (dec_pend) check("count step", remaining_dword_count, cnt_exp);
      dec_pend = !irdyn && !trdyn;
      cnt_exp = remaining_dword_count - 8'h01;
      if (!irdyn && !trdyn) begin
        rx++;
        check("frame in data", framen, 1'b0);
        check("word queued", exp_q.size() != 0, 1'b1);
        if (exp_q.size() != 0) check("pci word", {ad_out, cben_out}, exp_q.pop_front());
      end
    end else begin
      dec_pend = 1'b0;
    end
  end

  // ****************************************
  // Clock, main sequence, watchdog
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    seed = 32'h0000DB1C;
    {resetn, local_wide_request_n, local_ready_n, stall, dec_pend} = 5'h0E;
    {l_ad_in, local_byte_enables_n, requested_burst_length} = '0;
    errors = 0;
    num_checks = 0;
    @(negedge clk_sys);
    do_reset(12);
    run_xact(8'h01);
    run_xact(8'h08);
    for (int k = 0; k < 6; k++) run_xact(8'(rnd() % 12 + 1));
    report_and_stop();
  end

  // Bursts finish within a few thousand cycles; hang cut short well after
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### tb/pmw_pci_target_model.sv
/*
  Far side of the burst write path: bus arbiter grant and a PCI target
  that accepts a set number of data phases, with wait states on demand.
  Assumes one clock shared with the master.
*/
`timescale 1ns/1ps
`default_nettype none
module pmw_pci_target_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // From the master
  input  wire logic       reqn,
  input  wire logic       framen,
  input  wire logic       irdyn,
  // Bench control
  input  wire logic       stall,
  input  wire logic [7:0] limit,
  // To the master
  output logic            gntn,
  output logic            trdyn
);
  logic [7:0] done_r;
  logic [7:0] done_nxt;

  // Completed phases; both ready strobes low ends one
  always_comb begin
    done_nxt = done_r + ((!irdyn && !trdyn) ? 8'h01 : 8'h00);
  end

  // Grant tracks the request; trdy only inside a frame and below the limit,
  // so a burst longer than the limit is never accepted by accident
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gntn   <= 1'b1;
      trdyn  <= 1'b1;
      done_r <= 8'h00;
    end else begin
      gntn   <= reqn;
      trdyn  <= framen | stall | (done_nxt >= limit);
      done_r <= done_nxt;
    end
  end
endmodule
`default_nettype wire
